// ### design/burst_sram_device.sv
// Memory end of the link: burst-of-four double-rate static memory array.
`timescale 1ns/1ns
module burst_sram_device
   import burst_sram_pkg::*;
#(
   parameter int W = WIDTH_WIDE,
   parameter int A = ADDR_WIDE
) (
   // Link to the memory controller.
   burst_sram_link.device link,
   // Reset of the link-clock logic.
   input  wire logic      reset_n
);

   // ---------------------------------------------------------------------
   // Types and storage
   // ---------------------------------------------------------------------
   localparam int NB    = W / BYTE_BITS;
   localparam int WORDS = 2 ** (A + 2);

   typedef logic [W-1:0]  word_type;
   typedef logic [NB-1:0] be_type;

   typedef struct packed {
      logic [RD_LINE_DEPTH-1:0]          rd_line_v;
      logic [RD_LINE_DEPTH-1:0][A-1:0]   rd_line_a;
      logic                              out_on;
      logic [1:0]                        out_idx;
      logic [A-1:0]                      out_addr;
      word_type                          rdata;
      logic                              rvalid;
      logic                              echo;
      logic [WR_LINE_DEPTH-1:0]          wr_line_v;
      logic [WR_LINE_DEPTH-1:0][A-1:0]   wr_line_a;
      logic                              wr_on;
      logic [1:0]                        wr_idx;
      logic [A-1:0]                      wr_addr;
      logic [BURST_LEN-2:0][W-1:0]       wbuf_d;
      logic [BURST_LEN-2:0][NB-1:0]      wbuf_be;
      logic [BURST_LEN-2:0]              wbuf_v;
   } state_type;

   // Only the two documented widths are served; any positive address width is accepted.
   if (!(W == WIDTH_WIDE || W == WIDTH_NARROW) || A < 1) begin : bad_size
      $error("burst_sram_device: width must be 18 or 36 and address positive");
   end

   word_type  mem [0:WORDS-1];
   state_type s_q;
   state_type s_d;
   logic      lat_long;
   logic      tap_v;
   logic [A-1:0] tap_a;
   logic [1:0]   rd_idx;
   logic [A-1:0] rd_a;
   word_type     rd_word;
   logic         commit;
   word_type     cd  [BURST_LEN];
   be_type       cbe [BURST_LEN];

   // Replaces each byte of a word whose enable is low.
   function automatic word_type merge_bytes(input word_type old, input word_type upd,
                                            input be_type be_n);
      word_type res;
      res = old;
      for (int j = 0; j < NB; j++) begin
         if (!be_n[j]) begin
            res[j*BYTE_BITS +: BYTE_BITS] = upd[j*BYTE_BITS +: BYTE_BITS];
         end
      end
      return res;
   endfunction

   // ---------------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------------
   always_comb begin
      s_d = s_q;

      // The loop on/off pin picks the read latency; no other latency exists.
      lat_long = link.dll_off_n;
      tap_v    = lat_long ? s_q.rd_line_v[RD_LAT_DLL_BEATS-1]
                          : s_q.rd_line_v[RD_LAT_NODLL_BEATS-1];
      tap_a    = lat_long ? s_q.rd_line_a[RD_LAT_DLL_BEATS-1]
                          : s_q.rd_line_a[RD_LAT_NODLL_BEATS-1];

      // Commands count only on primary-clock beats; inverted beats carry data.
      s_d.rd_line_v = {s_q.rd_line_v[RD_LINE_DEPTH-2:0],
                       link.k_phase & ~link.read_sel_n};
      s_d.rd_line_a = {s_q.rd_line_a[RD_LINE_DEPTH-2:0], link.word_address};
      s_d.wr_line_v = {s_q.wr_line_v[WR_LINE_DEPTH-2:0],
                       link.k_phase & ~link.write_sel_n};
      s_d.wr_line_a = {s_q.wr_line_a[WR_LINE_DEPTH-2:0], link.word_address};

      // Read beat selection: beat zero at the tap, then the running burst.
      // Reads are at least four beats apart, so a tap never meets a live burst.
      rd_idx  = tap_v ? 2'h0 : s_q.out_idx;
      rd_a    = tap_v ? tap_a : s_q.out_addr;
      rd_word = mem[{rd_a, rd_idx}];
      for (int k = 0; k < BURST_LEN - 1; k++) begin
         if (s_q.wbuf_v[k] && s_q.wr_addr == rd_a && rd_idx == 2'(k)) begin
            rd_word = merge_bytes(rd_word, s_q.wbuf_d[k], s_q.wbuf_be[k]);
         end
      end

      // The data register updates on each beat of a burst and holds otherwise; valid is high only on those beats.
      s_d.rvalid = tap_v | s_q.out_on;
      if (tap_v | s_q.out_on) begin
         s_d.rdata = rd_word;
      end
      if (tap_v) begin
         s_d.out_on   = 1'b1;
         s_d.out_idx  = 2'h1;
         s_d.out_addr = tap_a;
      end else if (s_q.out_on) begin
         s_d.out_idx = s_q.out_idx + 2'h1;
         s_d.out_on  = (s_q.out_idx != 2'h3);
      end

      // The echo follows the output clock pair, or the input pair when both
      // output clocks are parked high.
      if (link.out_clk_true & link.out_clk_inv) begin
         s_d.echo = link.k_phase;
      end else begin
         s_d.echo = link.out_clk_true;
      end

      // Write capture: four beats from one cycle after the command.
      commit = s_q.wr_on && s_q.wr_idx == 2'h3;
      if (s_q.wr_line_v[WR_FIRST_BEAT-1]) begin
         s_d.wr_on      = 1'b1;
         s_d.wr_idx     = 2'h1;
         s_d.wr_addr    = s_q.wr_line_a[WR_FIRST_BEAT-1];
         s_d.wbuf_v     = '0;
         s_d.wbuf_v[0]  = 1'b1;
         s_d.wbuf_d[0]  = link.write_data_in;
         s_d.wbuf_be[0] = link.byte_enable_n;
      end else if (s_q.wr_on) begin
         s_d.wr_idx = s_q.wr_idx + 2'h1;
         if (commit) begin
            s_d.wr_on  = 1'b0;
            s_d.wbuf_v = '0;
         end else begin
            s_d.wbuf_v[s_q.wr_idx]  = 1'b1;
            s_d.wbuf_d[s_q.wr_idx]  = link.write_data_in;
            s_d.wbuf_be[s_q.wr_idx] = link.byte_enable_n;
         end
      end

      // Commit words: three buffered beats plus the last beat from the pins.
      for (int k = 0; k < BURST_LEN - 1; k++) begin
         cd[k]  = s_q.wbuf_d[k];
         cbe[k] = s_q.wbuf_be[k];
      end
      cd[BURST_LEN-1]  = link.write_data_in;
      cbe[BURST_LEN-1] = link.byte_enable_n;
   end

   // ---------------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------------
   always_ff @(posedge link.beat_clk or negedge reset_n) begin
      if (!reset_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // ---------------------------------------------------------------------
   // Array
   // ---------------------------------------------------------------------
   // The array has no reset; a whole burst is written on one rising edge of beat_clk.
   always_ff @(posedge link.beat_clk) begin
      if (commit) begin
         for (int i = 0; i < BURST_LEN; i++) begin
            for (int j = 0; j < NB; j++) begin
               if (!cbe[i][j]) begin
                  mem[{s_q.wr_addr, 2'(i)}][j*BYTE_BITS +: BYTE_BITS] <=
                     cd[i][j*BYTE_BITS +: BYTE_BITS];
               end
            end
         end
      end
   end

   // ---------------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------------
   // The read port also carries bytes forwarded from the write capture buffer.
   assign link.read_data_out        = s_q.rdata;
   assign link.read_valid           = s_q.rvalid;
   assign link.echo_strobe_true     = s_q.echo;
   assign link.echo_strobe_inverted = ~s_q.echo;

endmodule

// ### design/burst_sram_pkg.sv
// Shared constants for the burst-of-four double-rate static memory link.
package burst_sram_pkg;

   // ---------------------------------------------------------------------
   // Organisation
   // ---------------------------------------------------------------------
   localparam int BURST_LEN    = 4;
   localparam int BYTE_BITS    = 9;
   localparam int WIDTH_WIDE   = 36;
   localparam int WIDTH_NARROW = 18;
   localparam int ADDR_WIDE    = 19;   // Burst address bits of the wide organisation.
   localparam int ADDR_NARROW  = 20;   // Burst address bits of the narrow organisation.

   // ---------------------------------------------------------------------
   // Latencies, counted in beats (half input clock cycles)
   // ---------------------------------------------------------------------
   localparam int RD_LAT_DLL_BEATS   = 3;   // One and a half cycles.
   localparam int RD_LAT_NODLL_BEATS = 2;   // One cycle.
   localparam int WR_FIRST_BEAT      = 2;   // One cycle after the command.
   localparam int RD_LINE_DEPTH      = RD_LAT_DLL_BEATS;
   localparam int WR_LINE_DEPTH      = WR_FIRST_BEAT;

   // ---------------------------------------------------------------------
   // Clocking
   // ---------------------------------------------------------------------
   localparam int DLL_OFF_MAX_MHZ = 167;
   localparam int MCLK_PERIOD_NS  = 4;
   localparam int LINK_PERIOD_NS  = 32;
   localparam int BEAT_DIV        = LINK_PERIOD_NS / (2 * MCLK_PERIOD_NS);
   localparam int DIV_BITS        = 8;

   // Input clock frequency in MHz that a beat divider produces.
   function automatic int link_mhz(input int div);
      return 1000 / (4 * div * MCLK_PERIOD_NS);
   endfunction

endpackage

// ### design/burst_sram_link.sv
// Link between the memory controller and the burst-of-four memory.
`timescale 1ns/1ns
interface burst_sram_link
   import burst_sram_pkg::*;
#(
   parameter int W = WIDTH_WIDE,
   parameter int A = ADDR_WIDE
) ();
   localparam int NB = W / BYTE_BITS;

   // Every rising edge of beat_clk is one data beat; k_phase is high on the
   // beats of the primary input clock and low on those of the inverted one.
   logic              beat_clk;
   logic              k_phase;
   logic              read_sel_n;
   logic              write_sel_n;
   logic [A-1:0]      word_address;
   logic [W-1:0]      write_data_in;
   logic [NB-1:0]     byte_enable_n;
   logic              out_clk_true;
   logic              out_clk_inv;
   logic              dll_off_n;
   logic [W-1:0]      read_data_out;
   logic              read_valid;
   logic              echo_strobe_true;
   logic              echo_strobe_inverted;

   modport device (
      input  beat_clk, k_phase, read_sel_n, write_sel_n, word_address,
      input  write_data_in, byte_enable_n, out_clk_true, out_clk_inv, dll_off_n,
      output read_data_out, read_valid, echo_strobe_true, echo_strobe_inverted
   );

   modport host (
      output beat_clk, k_phase, read_sel_n, write_sel_n, word_address,
      output write_data_in, byte_enable_n, out_clk_true, out_clk_inv, dll_off_n,
      input  read_data_out, read_valid, echo_strobe_true, echo_strobe_inverted
   );

endinterface

// ### design/level_sync3.sv
// Three-stage level synchroniser whose output moves once stages two and three agree.
`timescale 1ns/1ns
module level_sync3 (
   // Clock and reset.
   input  wire logic clk,
   input  wire logic reset_n,
   // Level in and out.
   input  wire logic din,
   output logic      dout
);

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic out;
   } sync_type;

   sync_type s_q;
   sync_type s_d;

   // The first stage feeds only the second, so no logic sees a metastable value.
   always_comb begin
      s_d     = s_q;
      s_d.s1  = din;
      s_d.s2  = s_q.s1;
      s_d.s3  = s_q.s2;
      s_d.out = (s_q.s2 == s_q.s3) ? s_q.s3 : s_q.out;
   end

   // State register.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign dout = s_q.out;

endmodule

// ### design/burst_sram_host.sv
// Controller end of the link: makes the link clock and issues bursts.
`timescale 1ns/1ns
module burst_sram_host
   import burst_sram_pkg::*;
#(
   parameter int W           = WIDTH_WIDE,
   parameter int A           = ADDR_WIDE,
   parameter int DIV         = BEAT_DIV,
   parameter bit USE_OUT_CLK = 1'b0,
   parameter bit DLL_ON      = 1'b1,
   localparam int NB         = W / BYTE_BITS
) (
   // Clock and reset.
   input  wire logic                   mclk,
   input  wire logic                   reset_n,
   // Write requests.
   input  wire logic                   wr_valid,
   output logic                        wr_ready,
   input  wire logic [A-1:0]           wr_addr,
   input  wire logic [BURST_LEN*W-1:0] wr_data,
   input  wire logic [BURST_LEN*NB-1:0] wr_be_n,
   // Read requests.
   input  wire logic                   rd_valid,
   output logic                        rd_ready,
   input  wire logic [A-1:0]           rd_addr,
   // Read beats.
   output logic [W-1:0]                rd_data,
   output logic                        rd_data_valid,
   // Link to the memory.
   burst_sram_link.host                link
);

   // ---------------------------------------------------------------------
   // Checks and state
   // ---------------------------------------------------------------------
   // At least three mclk cycles per beat-half are needed for the echo synchroniser.
   if (!(W == WIDTH_WIDE || W == WIDTH_NARROW) || DIV < 3 || DIV > 255 ||
       (!DLL_ON && link_mhz(DIV) > DLL_OFF_MAX_MHZ)) begin : bad_cfg
      $error("burst_sram_host: unsupported width, divider or loop-off speed");
   end

   typedef struct packed {
      logic [DIV_BITS-1:0]    div;
      logic                   bclk;
      logic                   phase;
      logic                   slot;
      logic                   rsel_n;
      logic                   wsel_n;
      logic [A-1:0]           addr;
      logic [W-1:0]           dout;
      logic [NB-1:0]          be_n;
      logic                   wr_pend;
      logic                   wr_run;
      logic [2:0]             wb;
      logic [A-1:0]           wr_a;
      logic [BURST_LEN*W-1:0] wr_d;
      logic [BURST_LEN*NB-1:0] wr_be;
      logic                   rd_pend;
      logic [A-1:0]           rd_a;
      logic [W-1:0]           rdata;
      logic                   rdv;
      logic                   echo_last;
   } state_type;

   state_type s_q;
   state_type s_d;
   logic      tick;
   logic      echo_s;
   int        beat;

   // Echo strobe crosses into mclk; data is sampled on its synchronised edge.
   level_sync3 echo_sync (
      .clk     (mclk),
      .reset_n (reset_n),
      .din     (link.echo_strobe_true),
      .dout    (echo_s)
   );

   // ---------------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------------
   always_comb begin
      s_d     = s_q;
      s_d.rdv = 1'b0;
      beat    = 0;
      tick    = (s_q.div == DIV_BITS'(DIV - 1));
      s_d.div = tick ? '0 : s_q.div + 1'b1;
      if (tick) begin
         s_d.bclk = ~s_q.bclk;
      end

      // One request of each kind is held until it has gone out.
      if (wr_valid && !s_q.wr_pend) begin
         s_d.wr_pend = 1'b1;
         s_d.wr_a    = wr_addr;
         s_d.wr_d    = wr_data;
         s_d.wr_be   = wr_be_n;
      end
      if (rd_valid && !s_q.rd_pend) begin
         s_d.rd_pend = 1'b1;
         s_d.rd_a    = rd_addr;
      end

      // Link outputs change on the falling edge, mid-beat, for margin.
      if (tick && s_q.bclk) begin
         s_d.phase  = ~s_q.phase;
         s_d.rsel_n = 1'b1;
         s_d.wsel_n = 1'b1;
         if (!s_q.phase) begin
            // Primary beats alternate between read slot and write slot.
            s_d.slot = ~s_q.slot;
            if (!s_q.slot && s_q.rd_pend) begin
               s_d.rsel_n  = 1'b0;
               s_d.addr    = s_q.rd_a;
               s_d.rd_pend = 1'b0;
            end else if (s_q.slot && s_q.wr_pend && !s_q.wr_run) begin
               s_d.wsel_n = 1'b0;
               s_d.addr   = s_q.wr_a;
               s_d.wr_run = 1'b1;
               s_d.wb     = 3'h0;
            end
         end
         if (s_q.wr_run) begin
            s_d.wb = s_q.wb + 3'h1;
            if (s_q.wb == 3'(WR_FIRST_BEAT + BURST_LEN - 1)) begin
               s_d.wr_run  = 1'b0;
               s_d.wr_pend = 1'b0;
            end else if (s_d.wb >= 3'(WR_FIRST_BEAT)) begin
               beat     = int'(s_d.wb) - WR_FIRST_BEAT;
               s_d.dout = s_q.wr_d[beat*W +: W];
               s_d.be_n = s_q.wr_be[beat*NB +: NB];
            end
         end
      end

      // Each synchronised echo edge marks a stable beat on the read port.
      if (echo_s != s_q.echo_last) begin
         s_d.echo_last = echo_s;
         if (link.read_valid) begin
            s_d.rdata = link.read_data_out;
            s_d.rdv   = 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------------
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         s_q        <= '0;
         s_q.rsel_n <= 1'b1;
         s_q.wsel_n <= 1'b1;
         s_q.be_n   <= '1;
      end else begin
         s_q <= s_d;
      end
   end

   // ---------------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------------
   assign wr_ready           = ~s_q.wr_pend;
   assign rd_ready           = ~s_q.rd_pend;
   assign rd_data            = s_q.rdata;
   assign rd_data_valid      = s_q.rdv;
   assign link.beat_clk      = s_q.bclk;
   assign link.k_phase       = s_q.phase;
   assign link.read_sel_n    = s_q.rsel_n;
   assign link.write_sel_n   = s_q.wsel_n;
   assign link.word_address  = s_q.addr;
   assign link.write_data_in = s_q.dout;
   assign link.byte_enable_n = s_q.be_n;
   // Parking both output clocks high hands read timing to the input clock.
   assign link.out_clk_true  = USE_OUT_CLK ? s_q.phase : 1'b1;
   assign link.out_clk_inv   = USE_OUT_CLK ? ~s_q.phase : 1'b1;
   assign link.dll_off_n     = DLL_ON;

endmodule

// ### verification/burst_sram_chk.sv
// Checker for the link between the memory controller and the burst memory.
`timescale 1ns/1ns
module burst_sram_chk (
   // Link clock and reset.
   input wire logic beat_clk,
   input wire logic reset_n,
   // Command side.
   input wire logic k_phase,
   input wire logic read_sel_n,
   input wire logic write_sel_n,
   // Read return side.
   input wire logic read_valid,
   input wire logic echo_strobe_true,
   input wire logic echo_strobe_inverted
);
   // Commands count only on primary beats, so they are qualified here once.
   logic rd_cmd;
   logic wr_cmd;
   assign rd_cmd = !read_sel_n && k_phase;
   assign wr_cmd = !write_sel_n && k_phase;

   default clocking cb @(posedge beat_clk); endclocking
   default disable iff (!reset_n);

   // -----------------------------------------------------------------
   // Sequences and properties
   // -----------------------------------------------------------------
   sequence s_rd_cmd;
      rd_cmd;
   endsequence
   sequence s_rd_burst;
      read_valid [*4];
   endsequence
   property p_rd_on_k;     !read_sel_n |-> k_phase; endproperty
   property p_wr_on_k;     !write_sel_n |-> k_phase; endproperty
   property p_alt_slot;    rd_cmd |-> write_sel_n; endproperty
   property p_rd_space;    rd_cmd |=> !rd_cmd [*3]; endproperty
   property p_wr_space;    wr_cmd |=> !wr_cmd [*3]; endproperty
   property p_k_alt;       k_phase |=> !k_phase; endproperty
   property p_rd_lat;      s_rd_cmd |-> ##4 s_rd_burst; endproperty
   property p_rd_cause;    $rose(read_valid) |-> $past(rd_cmd, 4); endproperty
   property p_first_inv;   $rose(read_valid) |-> !echo_strobe_true; endproperty
   property p_echo_pair;   echo_strobe_inverted == !echo_strobe_true; endproperty
   property p_echo_toggle; read_valid |-> echo_strobe_true != $past(echo_strobe_true);
   endproperty

   a_rd_on_k:     assert property (p_rd_on_k) else $error("read select off a primary beat");
   a_wr_on_k:     assert property (p_wr_on_k) else $error("write select off a primary beat");
   a_alt_slot:    assert property (p_alt_slot) else $error("read and write on one beat");
   a_rd_space:    assert property (p_rd_space) else $error("reads too close");
   a_wr_space:    assert property (p_wr_space) else $error("writes too close");
   a_k_alt:       assert property (p_k_alt) else $error("beat phase did not alternate");
   a_rd_lat:      assert property (p_rd_lat) else $error("read burst late or short");
   a_rd_cause:    assert property (p_rd_cause) else $error("read data without command");
   a_first_inv:   assert property (p_first_inv) else $error("first beat on wrong phase");
   a_echo_pair:   assert property (p_echo_pair) else $error("echo strobes not complementary");
   a_echo_toggle: assert property (p_echo_toggle) else $error("echo idle during data");
endmodule

// ### verification/tb_burst_sram.sv
// Self-checking bench joining the controller end and the memory end.
`timescale 1ns/1ns
module tb_burst_sram;
   import burst_sram_pkg::*;
   localparam int W  = WIDTH_WIDE;
   localparam int A  = 8;
   localparam int NB = W / BYTE_BITS;

   logic                   mclk, reset_n, wr_valid, rd_valid, wr_ready, rd_ready, rd_data_valid;
   logic [A-1:0]           wr_addr, rd_addr;
   logic [4*W-1:0]         wr_data;
   logic [4*NB-1:0]        wr_be_n;
   logic [W-1:0]           rd_data;
   logic [W-1:0]           mem [0:(1<<(A+2))-1];
   logic [W-1:0]           exp_q [$];
   int                     bad_count, num_checks;

   burst_sram_link #(.W(W), .A(A)) burst_sram_link_i ();
   burst_sram_host #(.W(W), .A(A)) burst_sram_host_i (.mclk(mclk), .reset_n(reset_n),
      .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data),
      .wr_be_n(wr_be_n), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_addr(rd_addr),
      .rd_data(rd_data), .rd_data_valid(rd_data_valid), .link(burst_sram_link_i));
   burst_sram_device #(.W(W), .A(A)) burst_sram_device_i (.link(burst_sram_link_i),
      .reset_n(reset_n));
   burst_sram_chk burst_sram_chk_i (.beat_clk(burst_sram_link_i.beat_clk), .reset_n(reset_n),
      .k_phase(burst_sram_link_i.k_phase), .read_sel_n(burst_sram_link_i.read_sel_n),
      .write_sel_n(burst_sram_link_i.write_sel_n), .read_valid(burst_sram_link_i.read_valid),
      .echo_strobe_true(burst_sram_link_i.echo_strobe_true),
      .echo_strobe_inverted(burst_sram_link_i.echo_strobe_inverted));

   // -----------------------------------------------------------------
   // Shared tasks
   // -----------------------------------------------------------------
   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic hang();
      bad_count++;
      $display("MISMATCH %0t wait ran out", $time);
      results();
   endtask

   task automatic check(input logic [W-1:0] seen, input logic [W-1:0] want);
      num_checks++;
      if (seen !== want) begin
         bad_count++;
         $display("MISMATCH %0t read word %h expected %h", $time, seen, want);
      end
   endtask

   // Waits, sampling just after an edge, until the chosen ready is high.
   task automatic wait_hi(input bit rd);
      int n;
      n = 0;
      while ((rd ? rd_ready : wr_ready) !== 1'b1) begin
         @(posedge mclk);
         #1;
         n++;
         if (n > 4000) hang();
      end
   endtask

   // Issues one write burst and merges it into the reference image.
   task automatic wr(input logic [A-1:0] a, input logic [4*W-1:0] d, input logic [4*NB-1:0] be);
      int n;
      wait_hi(1'b0);
      wr_addr = a;
      wr_data = d;
      wr_be_n = be;
      wr_valid = 1'b1;
      for (int k = 0; k < 4; k++) begin
         for (int j = 0; j < NB; j++) begin
            if (!be[k*NB+j]) mem[{a, 2'(k)}][j*9+:9] = d[k*W+j*9+:9];
         end
      end
      @(posedge mclk);
      #1;
      wr_valid = 1'b0;
      // The controller keeps no order between kinds, so a read issued before this
      // write reaches the link could overtake it; wait for the write command.
      n = 0;
      while (burst_sram_link_i.write_sel_n !== 1'b0) begin
         @(posedge mclk);
         #1;
         n++;
         if (n > 4000) hang();
      end
   endtask

   // Issues one read burst; the words it must return are queued in order.
   task automatic rd(input logic [A-1:0] a);
      wait_hi(1'b1);
      rd_addr = a;
      rd_valid = 1'b1;
      for (int k = 0; k < 4; k++) exp_q.push_back(mem[{a, 2'(k)}]);
      @(posedge mclk);
      #1;
      rd_valid = 1'b0;
   endtask

   // Collects n returned words; a pulse lasts one cycle, so every cycle is looked at.
   task automatic collect(input int n);
      int t;
      t = 0;
      while (n > 0) begin
         @(posedge mclk);
         #1;
         t++;
         if (rd_data_valid === 1'b1) begin
            check(rd_data, exp_q.pop_front());
            n--;
         end
         if (t > 4000) hang();
      end
   endtask

   function automatic logic [4*W-1:0] pat(input logic [W-1:0] s);
      return {s ^ 36'hF0F0F0F03, s ^ 36'h0FF00FF02, s ^ 36'h123456781, s};
   endfunction

   // -----------------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------------
   task automatic t_full();
      wr(8'h05, pat(36'hA5A5A5A50), 16'h0000);
      // The write still occupies the link, so no second write is taken yet.
      check(W'(wr_ready), '0);
      rd(8'h05);
      // The read waits for its slot, so the request stays refused until then.
      check(W'(rd_ready), '0);
      collect(4);
   endtask

   // Enables change beat by beat: odd bytes, even bytes, none, all.
   task automatic t_mask();
      wr(8'h05, pat(36'h3C3C3C3C0), 16'h0FA5);
      rd(8'h05);
      collect(4);
   endtask

   // A read right behind a write to the same burst must see the new words.
   task automatic t_coherent();
      wr(8'h12, pat(36'h600DF00D0), 16'h0000);
      rd(8'h12);
      collect(4);
   endtask

   // A write and a read at once, then two reads back to back.
   task automatic t_concurrent();
      fork
         wr(8'hFF, pat(36'h0BADCAFE0), 16'h0000);
         rd(8'h12);
      join
      collect(4);
      rd(8'hFF);
      rd(8'h05);
      collect(8);
   endtask

   // -----------------------------------------------------------------
   // Clock, reset and main sequence
   // -----------------------------------------------------------------
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   initial begin
      bad_count = 0;
      num_checks = 0;
      reset_n = 1'b0;
      {wr_valid, rd_valid, wr_addr, rd_addr, wr_data} = '0;
      wr_be_n = '1;
      repeat (5) @(posedge mclk);
      #1;
      reset_n = 1'b1;
      t_full();
      t_mask();
      t_coherent();
      t_concurrent();
      results();
   end
endmodule
